// >>> shared/acs_defines.svh
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH
`define ACS_ADDR_CTRL 8'h00
`define ACS_ADDR_OPTION 8'h04
`define ACS_ADDR_STATUS 8'h08
`define ACS_RES_PAGE 3'h1
`define ACS_CTRL_RST 7'h00
`define ACS_OPT_PWR_BIT 0
`define ACS_OPT_CONVERTER_CLOCK_SOURCE_BIT 1
`define ACS_SEL_LOW_REF 4'hD
`define ACS_SEL_RESERVED 2'h2
`define ACS_LAST_OF4 3'h3
`define ACS_LAST_OF8 3'h7
`define ACS_RES_PAD 6'h00
`define ACS_RESP_OKAY 2'h0
`define ACS_RESP_SLVERR 2'h2
`define ACS_CLK_PERIOD_NS 10
`define ACS_PWR_SETTLE_US 100
`define ACS_RC_SETTLE_MS 10
`define ACS_PWR_SETTLE_CYC ((`ACS_PWR_SETTLE_US * 1000 + `ACS_CLK_PERIOD_NS - 1) / `ACS_CLK_PERIOD_NS)
`define ACS_RC_SETTLE_CYC ((`ACS_RC_SETTLE_MS * 1000000 + `ACS_CLK_PERIOD_NS - 1) / `ACS_CLK_PERIOD_NS)
`define ACS_SETTLE_W 20
`endif

// >>> shared/acs_pkg.sv
package acs_pkg;
  typedef struct packed {
    logic scan;
    logic eight_conversion_select;
    logic multi_channel_select;
    logic [3:0] chan_sel;
  } acs_ctrl_t;

  typedef struct packed {
    logic [3:0] mux_sel;
    logic start;
    logic power;
    logic clk_rc;
  } acs_core_req_t;

  typedef struct packed {
    logic done;
    logic [9:0] data;
  } acs_core_rsp_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_WAIT = 2'b11,
    ST_STORE = 2'b10
  } acs_state_t;
endpackage

// >>> logic/acs_result_mem.sv
`timescale 1ns/1ns
module acs_result_mem (
  input wire logic i_ref_clk, // system clock
  input wire logic i_reset, // sync reset, high
  input wire logic i_we, // write strobe
  input wire logic [2:0] i_waddr, // slot written
  input wire logic [15:0] i_wdata, // left-justified result
  input wire logic [2:0] i_raddr, // slot read
  output logic [15:0] o_rdata // registered read data
);
  logic [15:0] mem_q [8];

  // slots need no reset: contents are undefined until first conversion
  always_ff @(posedge i_ref_clk) begin
    if (i_we) begin
      mem_q[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_rdata <= 16'h0000;
    end else begin
      o_rdata <= mem_q[i_raddr];
    end
  end
endmodule

// >>> logic/acs_conversion_sequencer.sv
`timescale 1ns/1ns
`include "acs_defines.svh"
module acs_conversion_sequencer #(
  parameter int unsigned PWR_SETTLE_CYC = `ACS_PWR_SETTLE_CYC,
  parameter int unsigned RC_SETTLE_CYC = `ACS_RC_SETTLE_CYC
) (
  input wire logic i_ref_clk, // 100 MHz system clock
  input wire logic i_reset, // sync reset, high
  input wire logic i_awvalid, // write address valid
  output logic o_awready, // write address ready
  input wire logic [7:0] i_awaddr, // write byte address
  input wire logic i_wvalid, // write data valid
  output logic o_wready, // write data ready
  input wire logic [31:0] i_wdata, // write data
  input wire logic [3:0] i_wstrb, // write byte lanes
  output logic o_bvalid, // write response valid
  input wire logic i_bready, // write response ready
  output logic [1:0] o_bresp, // write response
  input wire logic i_arvalid, // read address valid
  output logic o_arready, // read address ready
  input wire logic [7:0] i_araddr, // read byte address
  output logic o_rvalid, // read data valid
  input wire logic i_rready, // read data ready
  output logic [31:0] o_rdata, // read data
  output logic [1:0] o_rresp, // read response
  output acs_pkg::acs_core_req_t o_core, // to mux and converter core
  input acs_pkg::acs_core_rsp_t i_core // from converter core
);
  import acs_pkg::*;

  acs_ctrl_t ctrl_q;
  acs_state_t state_q;
  logic done_flag_q;
  logic power_q;
  logic clk_rc_q;
  logic run_q;
  logic [2:0] cnt_q;
  logic [3:0] mux_sel_q;
  logic start_q;
  logic [2:0] done_sync_q;
  logic done_lvl_q;
  logic done_evt;
  logic [9:0] data_q;
  logic [9:0] data2_q;
  logic [9:0] res_q;
  logic [3:0] chan_code;
  logic [3:0] mux_dec;
  logic [2:0] slot;
  logic [2:0] last_cnt;
  logic at_last;
  logic mem_we;
  logic [15:0] mem_wdata;
  logic [15:0] mem_rdata;
  logic [1:0] settle_ok;
  logic aw_hold_q;
  logic aw_hold_d;
  logic [7:0] aw_addr_q;
  logic w_hold_q;
  logic w_hold_d;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic wr_fire;
  logic ctrl_wr;
  logic opt_wr;
  logic arready_q;
  logic rd_pend_q;
  logic [7:0] rd_addr_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [31:0] rd_mux;
  logic rd_ok;

  // ---- converter done: pin from another clock, three stages
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      done_sync_q <= 3'h0;
      done_lvl_q <= 1'b0;
    end else begin
      done_sync_q <= {done_sync_q[1:0], i_core.done};
      if (done_sync_q[1] == done_sync_q[2]) begin
        done_lvl_q <= done_sync_q[2];
      end
    end
  end

  assign done_evt = done_sync_q[1] & done_sync_q[2] & ~done_lvl_q;

  // core holds data with done, so two stages line it up with done_evt
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      data_q <= 10'h000;
      data2_q <= 10'h000;
    end else begin
      data_q <= i_core.data;
      data2_q <= data_q;
    end
  end

  // ---- channel decode
  always_comb begin
    if (!ctrl_q.multi_channel_select) begin
      chan_code = ctrl_q.chan_sel;
    end else if (!ctrl_q.eight_conversion_select) begin
      chan_code = {ctrl_q.chan_sel[3:2], cnt_q[1:0]};
    end else begin
      chan_code = {1'b0, cnt_q};
    end
    // reserved group reads the low reference
    if (chan_code[3:2] == `ACS_SEL_RESERVED) begin
      mux_dec = `ACS_SEL_LOW_REF;
    end else begin
      mux_dec = chan_code;
    end
  end

  assign last_cnt = ctrl_q.eight_conversion_select ? `ACS_LAST_OF8 : `ACS_LAST_OF4;
  assign at_last = (cnt_q == last_cnt);
  // four-conversion modes use the upper four slots
  assign slot = ctrl_q.eight_conversion_select ? cnt_q : {1'b1, cnt_q[1:0]};
  assign mem_we = (state_q == ST_STORE);
  assign mem_wdata = {res_q, `ACS_RES_PAD};

  // ---- sequencer
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      state_q <= ST_IDLE;
      cnt_q <= 3'h0;
      start_q <= 1'b0;
      mux_sel_q <= 4'h0;
      res_q <= 10'h000;
    end else begin
      start_q <= 1'b0;
      if (!power_q || ctrl_wr) begin
        state_q <= ST_IDLE;
        cnt_q <= 3'h0;
      end else begin
        case (state_q)
          ST_IDLE: begin
            if (run_q) begin
              state_q <= ST_START;
            end
          end
          ST_START: begin
            // mux only moves on a clock edge, never mid-conversion
            mux_sel_q <= mux_dec;
            start_q <= 1'b1;
            state_q <= ST_WAIT;
          end
          ST_WAIT: begin
            if (done_evt) begin
              res_q <= data2_q;
              state_q <= ST_STORE;
            end
          end
          ST_STORE: begin
            if (at_last) begin
              cnt_q <= 3'h0;
              state_q <= ctrl_q.scan ? ST_START : ST_IDLE;
            end else begin
              cnt_q <= cnt_q + 3'h1;
              state_q <= ST_START;
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // a command written while powered down is kept but not run
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      run_q <= 1'b0;
    end else if (!power_q) begin
      run_q <= 1'b0;
    end else if (ctrl_wr) begin
      run_q <= 1'b1;
    end else if (mem_we && at_last && !ctrl_q.scan) begin
      run_q <= 1'b0;
    end
  end

  // write clears the flag even against a same-cycle set
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      done_flag_q <= 1'b0;
    end else if (ctrl_wr) begin
      done_flag_q <= 1'b0;
    end else if (mem_we && at_last && power_q) begin
      done_flag_q <= 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      ctrl_q <= `ACS_CTRL_RST;
      power_q <= 1'b0;
      clk_rc_q <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        ctrl_q <= w_data_q[6:0];
      end
      if (opt_wr) begin
        power_q <= w_data_q[`ACS_OPT_PWR_BIT];
        clk_rc_q <= w_data_q[`ACS_OPT_CONVERTER_CLOCK_SOURCE_BIT];
      end
    end
  end

  // ---- settle timers: power bias and RC oscillator
  generate
    for (genvar g = 0; g < 2; g++) begin : g_settle
      logic [`ACS_SETTLE_W-1:0] cnt_s_q;
      logic en;
      logic [`ACS_SETTLE_W-1:0] limit;
      assign en = (g == 0) ? power_q : clk_rc_q;
      assign limit = (g == 0) ? `ACS_SETTLE_W'(PWR_SETTLE_CYC) : `ACS_SETTLE_W'(RC_SETTLE_CYC);
      always_ff @(posedge i_ref_clk) begin
        if (i_reset || !en) begin
          cnt_s_q <= '0;
        end else if (cnt_s_q != limit) begin
          cnt_s_q <= cnt_s_q + `ACS_SETTLE_W'(1);
        end
      end
      assign settle_ok[g] = en && (cnt_s_q == limit);
    end
  endgenerate

  acs_result_mem u_mem (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_we(mem_we),
    .i_waddr(slot),
    .i_wdata(mem_wdata),
    .i_raddr(i_araddr[4:2]),
    .o_rdata(mem_rdata)
  );

  // ---- AXI4-Lite write side
  assign wr_fire = aw_hold_q & w_hold_q & ~bvalid_q;
  assign ctrl_wr = wr_fire && (aw_addr_q == `ACS_ADDR_CTRL) && w_strb_q[0];
  assign opt_wr = wr_fire && (aw_addr_q == `ACS_ADDR_OPTION) && w_strb_q[0];

  always_comb begin
    aw_hold_d = aw_hold_q;
    w_hold_d = w_hold_q;
    if (wr_fire) begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
    end else begin
      if (i_awvalid && awready_q) begin
        aw_hold_d = 1'b1;
      end
      if (i_wvalid && wready_q) begin
        w_hold_d = 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      awready_q <= ~aw_hold_d;
      wready_q <= ~w_hold_d;
      if (i_awvalid && awready_q) begin
        aw_addr_q <= i_awaddr;
      end
      if (i_wvalid && wready_q) begin
        w_data_q <= i_wdata;
        w_strb_q <= i_wstrb;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      bvalid_q <= 1'b0;
      bresp_q <= `ACS_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      if ((aw_addr_q == `ACS_ADDR_CTRL) || (aw_addr_q == `ACS_ADDR_OPTION) ||
          (aw_addr_q == `ACS_ADDR_STATUS) ||
          ((aw_addr_q[7:5] == `ACS_RES_PAGE) && (aw_addr_q[1:0] == 2'h0))) begin
        bresp_q <= `ACS_RESP_OKAY;
      end else begin
        bresp_q <= `ACS_RESP_SLVERR;
      end
    end else if (i_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ---- AXI4-Lite read side
  always_comb begin
    rd_ok = 1'b1;
    rd_mux = 32'h00000000;
    if (rd_addr_q == `ACS_ADDR_CTRL) begin
      rd_mux = {24'h000000, done_flag_q, ctrl_q};
    end else if (rd_addr_q == `ACS_ADDR_OPTION) begin
      rd_mux = {30'h00000000, clk_rc_q, power_q};
    end else if (rd_addr_q == `ACS_ADDR_STATUS) begin
      rd_mux = {29'h00000000, (state_q != ST_IDLE), settle_ok};
    end else if ((rd_addr_q[7:5] == `ACS_RES_PAGE) && (rd_addr_q[1:0] == 2'h0)) begin
      rd_mux = {16'h0000, mem_rdata};
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      arready_q <= 1'b0;
      rd_pend_q <= 1'b0;
      rd_addr_q <= 8'h00;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `ACS_RESP_OKAY;
    end else begin
      if (i_arvalid && arready_q) begin
        arready_q <= 1'b0;
        rd_pend_q <= 1'b1;
        rd_addr_q <= i_araddr;
      end else if (rd_pend_q) begin
        rd_pend_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= rd_mux;
        rresp_q <= rd_ok ? `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
      end else if (rvalid_q) begin
        if (i_rready) begin
          rvalid_q <= 1'b0;
          arready_q <= 1'b1;
        end
      end else begin
        arready_q <= 1'b1;
      end
    end
  end

  assign o_awready = awready_q;
  assign o_wready = wready_q;
  assign o_bvalid = bvalid_q;
  assign o_bresp = bresp_q;
  assign o_arready = arready_q;
  assign o_rvalid = rvalid_q;
  assign o_rdata = rdata_q;
  assign o_rresp = rresp_q;
  assign o_core = '{mux_sel: mux_sel_q, start: start_q, power: power_q, clk_rc: clk_rc_q};

  // ---- checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  a_write_restarts: assert property ((ctrl_wr && power_q) |=>
    (state_q == ST_IDLE && run_q) ##1 (state_q == ST_START))
    else $error("control write did not restart the sequence");
  a_flag_cleared: assert property (ctrl_wr |=> !done_flag_q)
    else $error("control write left the done flag set");
  a_power_abort: assert property (!power_q |=> (state_q == ST_IDLE && !run_q))
    else $error("power off did not abort the sequence");
  a_start_select: assert property ((state_q == ST_START && power_q && !ctrl_wr) |=>
    (start_q && state_q == ST_WAIT && o_core.mux_sel == $past(mux_dec)))
    else $error("start pulse or mux select wrong");
  a_no_reserved: assert property (o_core.mux_sel[3:2] != `ACS_SEL_RESERVED)
    else $error("reserved mux code driven");
  a_single_chan: assert property ((state_q == ST_WAIT && !ctrl_q.multi_channel_select &&
    ctrl_q.chan_sel[3:2] != `ACS_SEL_RESERVED) |-> o_core.mux_sel == ctrl_q.chan_sel)
    else $error("single channel mode converting wrong input");
  a_group_chan: assert property ((state_q == ST_WAIT && ctrl_q.multi_channel_select &&
    !ctrl_q.eight_conversion_select && ctrl_q.chan_sel[3:2] != `ACS_SEL_RESERVED) |->
    o_core.mux_sel == {ctrl_q.chan_sel[3:2], cnt_q[1:0]})
    else $error("group mode converting wrong input");
  a_all_eight: assert property ((state_q == ST_WAIT && ctrl_q.multi_channel_select &&
    ctrl_q.eight_conversion_select) |-> o_core.mux_sel == {1'b0, cnt_q})
    else $error("eight channel mode converting wrong input");
  a_slot_upper: assert property ((mem_we && !ctrl_q.eight_conversion_select) |-> slot[2])
    else $error("four-conversion result outside slots five to eight");
  a_result_pad: assert property (mem_we |-> mem_wdata[5:0] == `ACS_RES_PAD)
    else $error("result low bits not zero");
  a_once_stops: assert property ((mem_we && at_last && !ctrl_q.scan && power_q && !ctrl_wr)
    |=> (state_q == ST_IDLE && !run_q && done_flag_q))
    else $error("single scan did not halt with flag set");
  a_scan_wraps: assert property ((mem_we && at_last && ctrl_q.scan && power_q && !ctrl_wr)
    |=> (state_q == ST_START && cnt_q == 3'h0 && done_flag_q))
    else $error("continuous scan did not wrap");
  a_flag_holds: assert property ((done_flag_q && !ctrl_wr) |=> $stable(done_flag_q))
    else $error("done flag dropped without a control write");
endmodule

// >>> sim/acs_core_model.sv
`timescale 1ns/1ns
module acs_core_model (
  input wire logic i_ref_clk, // system clock
  input wire logic i_reset, // sync reset, high
  input acs_pkg::acs_core_req_t i_req, // from sequencer
  input wire logic i_slow, // long conversion time
  input wire logic [9:0] i_offs, // flips result bits
  output acs_pkg::acs_core_rsp_t o_rsp // to sequencer
);
  import acs_pkg::*;
  logic [4:0] wait_q;
  logic [2:0] hold_q;
  logic [9:0] val_q;
  function automatic logic [9:0] level(input logic [3:0] sel);
    case (sel)
      4'hC: level = 10'h3FF;
      4'h8, 4'h9, 4'hA, 4'hB, 4'hD: level = 10'h000;
      4'hE: level = 10'h200;
      default: level = {sel, 6'h2B};
    endcase
  endfunction
  // clocked from the system clock only, so sampling stays synchronous
  always_ff @(posedge i_ref_clk) begin
    if (i_reset || !i_req.power) begin
      wait_q <= 5'h00;
      hold_q <= 3'h0;
    end else if (i_req.start) begin
      wait_q <= i_slow ? 5'h14 : 5'h02;
      hold_q <= 3'h0;
      val_q <= level(i_req.mux_sel) ^ i_offs;
    end else if (wait_q == 5'h01) begin
      wait_q <= 5'h00;
      hold_q <= 3'h4;
    end else if (wait_q != 5'h00) begin
      wait_q <= wait_q - 5'h01;
    end else if (hold_q != 3'h0) begin
      hold_q <= hold_q - 3'h1;
    end
  end
  assign o_rsp.done = hold_q != 3'h0;
  // released data shows the inverse so a late sample cannot pass by luck
  assign o_rsp.data = o_rsp.done ? val_q : ~val_q;
endmodule

// >>> sim/tb_top.sv
`timescale 1ns/1ns
`include "acs_defines.svh"
module tb_top;
  import acs_pkg::*;
  logic clk, rst, awv, wv, arv, slow, awr, wrdy, bv, arr, rv;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdat, got;
  logic [9:0] offs;
  logic [1:0] br, rr;
  acs_core_req_t req;
  acs_core_rsp_t rsp;
  logic [31:0] eq[$];
  logic [31:0] mq[$];
  logic [1:0] rq[$];
  logic [1:0] bq[$];
  int error_cnt = 0;
  int n_compared = 0;
  acs_conversion_sequencer #(.PWR_SETTLE_CYC(8), .RC_SETTLE_CYC(16)) dut (
    .i_ref_clk(clk), .i_reset(rst), .i_awvalid(awv), .o_awready(awr), .i_awaddr(awa),
    .i_wvalid(wv), .o_wready(wrdy), .i_wdata(wd), .i_wstrb(4'hF), .o_bvalid(bv),
    .i_bready(1'b1), .o_bresp(br), .i_arvalid(arv), .o_arready(arr), .i_araddr(ara),
    .o_rvalid(rv), .i_rready(1'b1), .o_rdata(rdat), .o_rresp(rr), .o_core(req),
    .i_core(rsp));
  acs_core_model model (.i_ref_clk(clk), .i_reset(rst), .i_req(req), .i_slow(slow),
    .i_offs(offs), .o_rsp(rsp));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic finish_test;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic guard(input int n, input int lim = 60);
    if (n >= lim) begin
      error_cnt++;
      $display("[FAIL] t=%0t wait limit got=%h exp=%h", $time, n, lim);
      finish_test;
    end
  endtask
  // oldest note against each answer as it appears
  always @(posedge clk) begin
    if (rv) begin
      cmp(rdat & mq[0], eq[0] & mq[0]);
      cmp({30'h0, rr}, {30'h0, rq[0]});
      void'(eq.pop_front());
      void'(mq.pop_front());
      void'(rq.pop_front());
    end
    if (bv) cmp({30'h0, br}, {30'h0, bq.pop_front()});
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    bit pa, pw;
    bq.push_back(r);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    pa = 1;
    pw = 1;
    n = 0;
    while ((pa || pw) && n < 60) begin
      @(posedge clk);
      n++;
      if (pa && awr) begin
        awv <= 1'b0;
        pa = 0;
      end
      if (pw && wrdy) begin
        wv <= 1'b0;
        pw = 0;
      end
    end
    guard(n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!bv && n < 60);
    guard(n);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1,
                    input logic [1:0] r = 2'h0);
    int n;
    eq.push_back(e);
    mq.push_back(m);
    rq.push_back(r);
    ara <= a;
    arv <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!arr && n < 60);
    arv <= 1'b0;
    guard(n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!rv && n < 60);
    got = rdat;
    guard(n);
  endtask
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    int n;
    n = 0;
    // a slow eight-conversion pass takes about 210 cycles, three per poll
    do begin
      rd(a, 32'h0, 32'h0);
      n++;
    end while (got[b] !== v && n < 200);
    if (got[b] !== v) guard(200, 200);
  endtask
  task automatic run_seq(input logic [6:0] c, input logic cont);
    int k;
    logic [3:0] ch;
    offs <= 10'($urandom);
    wr(`ACS_ADDR_CTRL, {25'h0, c}, `ACS_RESP_OKAY);
    rd(`ACS_ADDR_CTRL, {25'h0, c});
    if (cont) begin
      poll(`ACS_ADDR_CTRL, 7, 1'b1);
      offs <= 10'($urandom);
      // continuous runs never return to idle; 700 cycles spans three slow passes
      repeat (700) @(posedge clk);
      rd(`ACS_ADDR_STATUS, 32'h4, 32'h4);
    end else begin
      poll(`ACS_ADDR_STATUS, 2, 1'b0);
    end
    rd(`ACS_ADDR_CTRL, {24'h0, 1'b1, c});
    for (k = c[5] ? 0 : 4; k < 8; k++) begin
      ch = !c[4] ? c[3:0] : c[5] ? 4'(k) : {c[3:2], 2'(k)};
      rd(8'h20 + 8'(4 * k), {16'h0, model.level(ch) ^ offs, 6'h00});
    end
  endtask
  logic [6:0] cfg[4] = '{7'h42, 7'h67, 7'h54, 7'h70};
  initial begin
    int i, n;
    rst = 1'b1;
    {awv, wv, arv, slow} = 4'h0;
    {awa, ara, wd, offs} = '0;
    void'($urandom(49));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rd(`ACS_ADDR_CTRL, 32'h0);
    rd(`ACS_ADDR_OPTION, 32'h0);
    rd(8'h40, 32'h0, '1, `ACS_RESP_SLVERR);
    wr(8'h40, 32'h1, `ACS_RESP_SLVERR);
    wr(`ACS_ADDR_OPTION, 32'h1, `ACS_RESP_OKAY);
    repeat (12) @(posedge clk);
    rd(`ACS_ADDR_STATUS, 32'h1, 32'h3);
    for (i = 0; i < 16; i++) begin
      slow <= i[0];
      run_seq({3'h0, 4'(i)}, 1'b0);
    end
    run_seq(7'h25, 1'b0);
    run_seq(7'h16, 1'b0);
    run_seq(7'h1D, 1'b0);
    run_seq(7'h3B, 1'b0);
    // catch a start pulse so the rewrite lands mid-conversion
    slow <= 1'b1;
    wr(`ACS_ADDR_CTRL, 32'h20, `ACS_RESP_OKAY);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (req.start !== 1'b1 && n < 60);
    guard(n);
    run_seq(7'h07, 1'b0);
    for (i = 0; i < 4; i++) begin
      slow <= cfg[i][0];
      run_seq(cfg[i], 1'b1);
      wr(`ACS_ADDR_OPTION, 32'h0, `ACS_RESP_OKAY);
      cmp({31'h0, req.power}, 32'h0);
      rd(`ACS_ADDR_STATUS, 32'h0, 32'h5);
      wr(`ACS_ADDR_OPTION, 32'h1, `ACS_RESP_OKAY);
      repeat (12) @(posedge clk);
    end
    wr(`ACS_ADDR_OPTION, 32'h3, `ACS_RESP_OKAY);
    @(posedge clk);
    cmp({31'h0, req.clk_rc}, 32'h1);
    repeat (30) @(posedge clk);
    rd(`ACS_ADDR_STATUS, 32'h3, 32'h3);
    run_seq(7'h0E, 1'b0);
    finish_test;
  end
endmodule
